// ### rtl/chain_link_pkg.sv
// Constants shared by the chained monitor serial link: frame fields,
// register addresses, reset values and pin slots of the sampled inputs.
// Assumes 32-bit frames, MSB of the frame on the wire first.
package chain_link_pkg;
    localparam int          FRAME_BITS    = 32;
    localparam int          CRC_BITS      = 22;
    localparam logic [5:0]  FRAME_BITS_C  = 6'h20;
    // Write frame field positions
    localparam int          ADDR_MSB      = 31;
    localparam int          ADDR_LSB      = 27;
    localparam int          REG_MSB       = 26;
    localparam int          REG_LSB       = 21;
    localparam int          DATA_MSB      = 20;
    localparam int          DATA_LSB      = 13;
    localparam int          ALL_BIT       = 12;
    localparam int          WCRC_MSB      = 10;
    localparam int          WCRC_LSB      = 3;
    localparam int          PAT_MSB       = 2;
    // Read frame field positions
    localparam int          COVER_LSB     = 10;
    localparam int          RCRC_MSB      = 9;
    localparam int          RCRC_LSB      = 2;
    localparam logic [2:0]  WRITE_PATTERN = 3'h2;
    localparam logic [7:0]  CRC_POLY      = 8'h2F;
    localparam logic [7:0]  CRC_INIT      = 8'h00;
    // Register addresses seen on the link
    localparam logic [5:0]  REG_CTRL_HIGH = 6'h0D;
    localparam logic [5:0]  REG_CTRL_LOW  = 6'h0E;
    localparam logic [5:0]  REG_READ_SEL  = 6'h1C;
    localparam logic [4:0]  ADDR_ZERO     = 5'h00;
    // Control field positions and values
    localparam int          LOCK_BIT      = 2;
    localparam int          CHAIN_BIT     = 0;
    localparam int          RDSEL_MSB     = 5;
    localparam int          RDSEL_LSB     = 4;
    localparam logic [1:0]  READ_OFF      = 2'h3;
    localparam logic [7:0]  CTRL_LOW_RST  = 8'h00;
    localparam logic [7:0]  CTRL_HIGH_RST = 8'h00;
    localparam logic [5:0]  READ_SEL_RST  = 6'h00;
    // Slots of the sampled pin vector
    localparam int          PIN_COUNT     = 7;
    // Reset levels of the sampled pins; alert from above starts idle (low)
    localparam logic [PIN_COUNT-1:0] PIN_RST = 7'h3F;
    localparam int          PIN_CS        = 0;
    localparam int          PIN_SCLK      = 1;
    localparam int          PIN_SDI       = 2;
    localparam int          PIN_CNV       = 3;
    localparam int          PIN_PD        = 4;
    localparam int          PIN_DABOVE    = 5;
    localparam int          PIN_AABOVE    = 6;
endpackage : chain_link_pkg

// ### rtl/stacked_monitor_chain_link.sv
// Serial command and readback engine of one device in a stacked monitor chain.
// Assumes clk is much faster than the link clock (10 MHz against 1.25 MHz or less)
// so every link clock edge is seen after the pin filters.
`timescale 1ns/100ps

// Overview of operation
// - Mirror the five host-side signals onto chain relay pins for eight-deep stacks.
// - Master takes select, clock, data, convert, power-down from host; slave from below.
// - Slave tristates serial out and alert; all devices relay data and alert downward.
// - One 32-bit write frame reaches any register of any stacked device.
// - Response shifts out during the same frame that shifts in the next command.
// - Device address is zero after power-up and after leaving power-down.
// - Recompute CRC over bits 31..11; skip the write on mismatch.
// - Low three bits must be 010 or the write is discarded.
// - Next frame bit 10 shows whether the previous write was accepted.
// - Check value is remainder by x^8+x^5+x^3+x^2+x+1.
// - Read frames carry CRC of bits 31..10 in bits 9..2.
// - Relayed words are rechecked; bad CRC replaced by inverse of own.
// - Device address goes LSB first; other fields MSB first.
// - CRC register starts at zero before covered bits enter.
module stacked_monitor_chain_link
    import chain_link_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        isMaster,
    input  wire logic [2:0]  chainPosition,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic        sdi,
    input  wire logic        convert_start_n,
    input  wire logic        power_down_n,
    input  wire logic        dataAbove,
    input  wire logic        alertAbove,
    input  wire logic        localAlert,
    input  wire logic [7:0]  regReadData,
    input  wire logic [3:0]  convChannel,
    input  wire logic [11:0] convData,
    output logic             csUpRelayN,
    output logic             clock_up_relay,
    output logic             sdiUpRelay,
    output logic             convertStartUpRelayN,
    output logic             powerDownUpRelayN,
    output logic             sdo,
    output logic             sdoOe,
    output logic             alertOut,
    output logic             alertOe,
    output logic             data_down_relay,
    output logic             alert_down_relay,
    output logic             writeStrobe,
    output logic [5:0]       writeReg,
    output logic [7:0]       writeData,
    output logic             convAdvance,
    output logic [4:0]       deviceAddress,
    output logic             writeAck
);

    typedef enum logic [1:0] {
        FRAME_IDLE  = 2'b00,
        FRAME_SHIFT = 2'b01
    } frame_e;

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] filt;
        frame_e               fs;
        logic [5:0]           cnt;
        logic [31:0]          rx;
        logic [31:0]          above;
        logic [31:0]          tx;
        logic [4:0]           devAddr;
        logic [7:0]           ctrlLow;
        logic [7:0]           ctrlHigh;
        logic [5:0]           readSel;
        logic                 ack;
        logic                 ownSent;
        logic                 alert;
        logic                 wrStb;
        logic [5:0]           wrReg;
        logic [7:0]           wrData;
        logic                 convAdv;
    } state_s;

    // CRC over 22 bits; a write pads one leading zero, which leaves a zero
    // register at zero and so gives the same 21-bit remainder
    function automatic logic [7:0] crc8(input logic [CRC_BITS-1:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = CRC_BITS - 1; i >= 0; i--) begin
            c = {c[6:0], d[i]} ^ (c[7] ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    // Device address travels LSB first, so the field is bit-reversed
    function automatic logic [4:0] rev5(input logic [4:0] a);
        return {a[0], a[1], a[2], a[3], a[4]};
    endfunction : rev5

    // Append the read CRC and the two reserved zero bits
    function automatic logic [31:0] sealRead(input logic [CRC_BITS-1:0] h);
        // CRC of the covered bits in the same frame
        return {h, crc8(h), 2'b00};
    endfunction : sealRead

    // Own reply word: select zero gives a conversion result, else a register
    function automatic logic [31:0] ownWord(input state_s s, input logic [7:0] ext,
                                            input logic [3:0] ch, input logic [11:0] cd);
        logic [7:0] b;
        case (s.readSel)
            REG_CTRL_LOW:  b = s.ctrlLow;
            REG_CTRL_HIGH: b = s.ctrlHigh;
            REG_READ_SEL:  b = {s.readSel, 2'b00};
            default:       b = ext;
        endcase
        // acknowledge of the last write sits in bit 10
        if (s.readSel == READ_SEL_RST) begin
            return sealRead({rev5(s.devAddr), ch, cd, s.ack});
        end
        return sealRead({rev5(s.devAddr), s.readSel, b, 2'b00, s.ack});
    endfunction : ownWord

    state_s q;
    state_s n;

    logic [PIN_COUNT-1:0] pinsIn;
    logic [PIN_COUNT-1:0] agree;
    logic                 sclkRise;
    logic                 sclkFall;
    logic                 csFall;
    logic                 csRise;
    logic [4:0]           rxAddr;
    logic                 wOk;
    logic                 addressed;
    logic                 exec;
    logic [31:0]          relayWord;
    logic [7:0]           relayCrc;
    logic                 reload;

    // one set of pins serves host or device below, same sampling
    assign pinsIn = {alertAbove, dataAbove, power_down_n, convert_start_n, sdi, sclk, csN};

    // A change counts once the second and third stages agree
    assign agree    = ~(q.s2 ^ q.s3);
    assign sclkRise = agree[PIN_SCLK] & q.s3[PIN_SCLK] & ~q.filt[PIN_SCLK];
    assign sclkFall = agree[PIN_SCLK] & ~q.s3[PIN_SCLK] & q.filt[PIN_SCLK];
    assign csFall   = agree[PIN_CS] & ~q.s3[PIN_CS] & q.filt[PIN_CS];
    assign csRise   = agree[PIN_CS] & q.s3[PIN_CS] & ~q.filt[PIN_CS];

    // Received write decode
    // address arrives LSB first
    assign rxAddr    = rev5(q.rx[ADDR_MSB:ADDR_LSB]);
    // recheck write CRC, fixed tail pattern
    assign wOk       = (crc8({1'b0, q.rx[ADDR_MSB:WCRC_MSB+1]}) == q.rx[WCRC_MSB:WCRC_LSB])
                       && (q.rx[PAT_MSB:0] == WRITE_PATTERN);
    // address match or broadcast; broadcast only with address zero
    assign addressed = q.rx[ALL_BIT] ? (rxAddr == ADDR_ZERO) : (rxAddr == q.devAddr);
    assign exec      = wOk && addressed;

    // relayed word with its CRC checked, inverted own CRC on mismatch
    assign relayCrc = crc8(q.above[ADDR_MSB:COVER_LSB]);
    always_comb begin
        relayWord = q.above;
        if (relayCrc != q.above[RCRC_MSB:RCRC_LSB]) begin
            relayWord[RCRC_MSB:RCRC_LSB] = ~relayCrc;
        end
    end

    // Next-state logic for sampling, framing, register writes and reply
    always_comb begin
        n         = q;
        reload    = 1'b0;
        n.wrStb   = 1'b0;
        n.convAdv = 1'b0;
        n.s1      = pinsIn;
        n.s2      = q.s1;
        n.s3      = q.s2;
        n.filt    = (agree & q.s3) | (~agree & q.filt);
        n.alert   = q.filt[PIN_AABOVE] | localAlert;
        case (q.fs)
            FRAME_IDLE: begin
                if (csFall) begin
                    n.fs  = FRAME_SHIFT;
                    n.cnt = 6'h00;
                end
            end
            FRAME_SHIFT: begin
                // command shifts in while the reply shifts out
                if (sclkRise && q.cnt < FRAME_BITS_C) begin
                    n.rx    = {q.rx[30:0], q.filt[PIN_SDI]};
                    n.above = {q.above[30:0], q.filt[PIN_DABOVE]};
                    n.cnt   = q.cnt + 6'h01;
                end
                if (sclkFall && q.cnt != 6'h00) begin
                    n.tx = {q.tx[30:0], 1'b0};
                end
                if (csRise) begin
                    n.fs = FRAME_IDLE;
                    // Short frames are ignored whole; long frames keep their first 32 bits
                    if (q.cnt == FRAME_BITS_C) begin
                        // accepted means CRC and pattern good
                        n.ack = wOk;
                        reload = 1'b1;
                        if (exec) begin
                            n.wrStb   = 1'b1;
                            n.wrReg   = q.rx[REG_MSB:REG_LSB];
                            n.wrData  = q.rx[DATA_MSB:DATA_LSB];
                            n.ownSent = 1'b0;
                            case (q.rx[REG_MSB:REG_LSB])
                                REG_CTRL_LOW: begin
                                    n.ctrlLow = q.rx[DATA_MSB:DATA_LSB];
                                    if (q.rx[DATA_LSB+LOCK_BIT]) begin
                                        n.devAddr = {2'b00, chainPosition};
                                    end
                                end
                                REG_CTRL_HIGH: n.ctrlHigh = q.rx[DATA_MSB:DATA_LSB];
                                REG_READ_SEL:  n.readSel  = q.rx[DATA_MSB:DATA_LSB+2];
                                default:       ;
                            endcase
                        end
                    end
                end
            end
            default: n.fs = FRAME_IDLE;
        endcase
        // address back to zero while powered down
        if (!n.filt[PIN_PD]) begin
            n.devAddr = ADDR_ZERO;
            n.ownSent = 1'b0;
        end
        // reply for the next frame, built last so a write just taken
        // shows in the very next answer; own word every frame unchained, chained once after each executed write or power-down unless read select is READ_OFF
        if (reload) begin
            if (!n.ctrlLow[CHAIN_BIT] || (!n.ownSent && n.ctrlHigh[RDSEL_MSB:RDSEL_LSB] != READ_OFF)) begin
                n.tx      = ownWord(n, regReadData, convChannel, convData);
                n.ownSent = 1'b1;
                n.convAdv = (n.readSel == READ_SEL_RST);
            end else begin
                // words from above follow the own word
                n.tx = relayWord;
            end
        end
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q          <= '0;
            // Idle pin levels, so no false alert follows reset
            q.s1       <= PIN_RST;
            q.s2       <= PIN_RST;
            q.s3       <= PIN_RST;
            q.filt     <= PIN_RST;
            q.fs       <= FRAME_IDLE;
            q.devAddr  <= ADDR_ZERO;
            q.ctrlLow  <= CTRL_LOW_RST;
            q.ctrlHigh <= CTRL_HIGH_RST;
            q.readSel  <= READ_SEL_RST;
            q.alert    <= 1'b0;
        end else if (ce) begin
            q <= n;
        end
    end

    // filtered copies go up to the next device
    assign csUpRelayN           = q.filt[PIN_CS];
    assign clock_up_relay       = q.filt[PIN_SCLK];
    assign sdiUpRelay           = q.filt[PIN_SDI];
    assign convertStartUpRelayN = q.filt[PIN_CNV];
    assign powerDownUpRelayN    = q.filt[PIN_PD];

    // host pins only driven on the master; relays always driven
    assign sdo              = (q.fs == FRAME_SHIFT) & q.tx[31];
    assign sdoOe            = isMaster;
    assign alertOut         = q.alert;
    assign alertOe          = isMaster;
    assign data_down_relay  = (q.fs == FRAME_SHIFT) & q.tx[31];
    assign alert_down_relay = q.alert;

    assign writeStrobe   = q.wrStb;
    assign writeReg      = q.wrReg;
    assign writeData     = q.wrData;
    assign convAdvance   = q.convAdv;
    assign deviceAddress = q.devAddr;
    assign writeAck      = q.ack;

endmodule : stacked_monitor_chain_link

// ### tb/host_link_model.sv
// Host and upper-neighbour model: frames words on csN/sclk/sdi, feeds
// dataAbove and reads the reply from the downward relay pin.
`timescale 1ns/100ps
module host_link_model (
    input  wire logic clk,
    input  wire logic replyBit,
    output logic      csN,
    output logic      sclk,
    output logic      sdi,
    output logic      dataAbove
);
    // Link clock stands low between frames
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        dataAbove = 1'b0;
    end

    // Words go out highest bit first
    // Half period of four clk, an 800 ns link clock
    // With chained readback off only own words are read back
    task automatic frame(input logic [31:0] cmd, input logic [31:0] above,
                         output logic [31:0] reply);
        repeat (2) @(negedge clk);
        csN = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 31; i >= 0; i--) begin
            sdi = cmd[i];
            dataAbove = above[i];
            repeat (4) @(negedge clk);
            reply[i] = replyBit;
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        // Released lines show the inverse, so a stale bit cannot pass
        sdi = ~cmd[0];
        dataAbove = ~above[0];
        repeat (8) @(negedge clk);
    endtask : frame
endmodule : host_link_model

// ### tb/chain_link_monitor.sv
// Port checker for the chained link engine.
// Assumes clk well above the link clock rate.
`timescale 1ns/100ps
module chain_link_monitor (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       csN,
    input wire logic       sclk,
    input wire logic       power_down_n,
    input wire logic       localAlert,
    input wire logic       isMaster,
    input wire logic       csUpRelayN,
    input wire logic       clock_up_relay,
    input wire logic       sdo,
    input wire logic       sdoOe,
    input wire logic       alertOut,
    input wire logic       alertOe,
    input wire logic       data_down_relay,
    input wire logic       alert_down_relay,
    input wire logic       writeStrobe,
    input wire logic [4:0] deviceAddress,
    input wire logic       writeAck
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence csFall; $fell(csN); endsequence
    sequence clkRise; $rose(sclk); endsequence
    a_cs_relay: assert property (csFall |-> ##[2:8] !csUpRelayN)
        else $error("select relay late");
    a_clk_relay: assert property (clkRise |-> ##[2:8] clock_up_relay)
        else $error("clock relay late");
    a_oe_master: assert property (sdoOe == isMaster && alertOe == isMaster)
        else $error("output enable wrong");
    a_down_copy: assert property (localAlert |=> alert_down_relay && data_down_relay == sdo)
        else $error("downward relay differs");
    a_alert_path: assert property ($rose(localAlert) |-> ##[1:4] alertOut)
        else $error("alert not passed");
    a_sdo_idle: assert property (csN [*8] |-> !sdo)
        else $error("sdo active between frames");
    a_pd_address: assert property (!power_down_n [*6] |-> deviceAddress == 5'h00)
        else $error("address kept in power-down");
    // Executed write is single and acknowledged
    a_strobe_ack: assert property (writeStrobe |-> ##[0:1] writeAck ##1 !writeStrobe)
        else $error("strobe without ack");
endmodule : chain_link_monitor

bind stacked_monitor_chain_link chain_link_monitor mon (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk),
    .power_down_n(power_down_n), .localAlert(localAlert), .isMaster(isMaster), .csUpRelayN(csUpRelayN),
    .clock_up_relay(clock_up_relay), .sdo(sdo), .sdoOe(sdoOe), .alertOut(alertOut), .alertOe(alertOe),
    .data_down_relay(data_down_relay), .alert_down_relay(alert_down_relay), .writeStrobe(writeStrobe),
    .deviceAddress(deviceAddress), .writeAck(writeAck));

// ### tb/stacked_monitor_chain_link_test.sv
// Self-checking bench for one stacked device's link engine.
// Assumes the host model also plays the device above.
`timescale 1ns/100ps
module stacked_monitor_chain_link_test;
    import chain_link_pkg::*;
    logic        clk, rst, isMaster, csN, sclk, sdi, cnvN, pdN, dAbove, aAbove, lAlert;
    logic        csR, ckR, sdiR, cnvR, pdR, sdo, sdoOe, aOut, aOe, dDown, aDown, wStb, cAdv, wAck;
    logic [5:0]  wReg;
    logic [7:0]  wData;
    logic [4:0]  devAddr;
    logic [31:0] r, w1, w2;
    int          err_count, check_count, strobes, advances;

    stacked_monitor_chain_link uut (.clk(clk), .rst(rst), .ce(1'b1), .isMaster(isMaster),
        .chainPosition(3'h2), .csN(csN), .sclk(sclk), .sdi(sdi), .convert_start_n(cnvN),
        .power_down_n(pdN), .dataAbove(dAbove), .alertAbove(aAbove), .localAlert(lAlert),
        .regReadData(8'h5A), .convChannel(4'h3), .convData(12'h9A5), .csUpRelayN(csR),
        .clock_up_relay(ckR), .sdiUpRelay(sdiR), .convertStartUpRelayN(cnvR),
        .powerDownUpRelayN(pdR), .sdo(sdo), .sdoOe(sdoOe), .alertOut(aOut), .alertOe(aOe),
        .data_down_relay(dDown), .alert_down_relay(aDown), .writeStrobe(wStb), .writeReg(wReg),
        .writeData(wData), .convAdvance(cAdv), .deviceAddress(devAddr), .writeAck(wAck));
    host_link_model host (.clk(clk), .replyBit(dDown), .csN(csN), .sclk(sclk), .sdi(sdi),
        .dataAbove(dAbove));

    // Clock and pulse counters
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (wStb === 1'b1) strobes++;
        if (cAdv === 1'b1) advances++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] crc8(input logic [21:0] b);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 21; i >= 0; i--) c = {c[6:0], b[i] ^ c[7]} ^ (c[7] ? 8'h2E : 8'h00);
        return c;
    endfunction : crc8

    function automatic logic [31:0] seal(input logic [21:0] b);
        return {b, crc8(b), 2'b00};
    endfunction : seal

    // Host-built broadcast write, device address zero under the CRC
    function automatic logic [31:0] wrAll(input logic [5:0] ra, input logic [7:0] d);
        logic [20:0] h;
        h = {5'h00, ra, d, 2'h2};
        return {h, crc8({1'b0, h}), 3'h2};
    endfunction : wrAll

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Bad CRC and bad tail refused, then lock and readback setup
    task automatic write_checks();
        host.frame(32'h01C2B6EA, 32'h0, r);
        host.frame(32'h01C2B6E3, 32'h0, r);
        chk(sdiR, 1'b0, "data relayed up");
        chk(r[10], 1'b0, "ack after bad crc");
        chk(r[9:2], crc8(r[31:10]), "read crc");
        host.frame(32'h01C2B6E2, 32'h0, r);
        chk(r[10], 1'b0, "ack after bad tail");
        chk(strobes, 1, "lock write executed");
        chk({wReg, wData}, {6'h0E, 8'h15}, "lock data");
        chk(devAddr, 5'h02, "address locked");
        host.frame(32'h038716CA, 32'h0, r);
        chk(r[10], 1'b1, "ack after good write");
        chk(r[9:2], crc8(r[31:10]), "own word crc");
        chk({wReg, wData}, {6'h1C, 8'h38}, "select write");
        chk(advances, 3, "conversion words advanced");
    endtask : write_checks

    // Broadcast control-high writes: acknowledge confirmation, then no-read relaying
    task automatic chain_checks();
        w2 = seal(22'h3A5C01);
        host.frame(wrAll(REG_CTRL_HIGH, 8'h00), w1, r);
        chk(r, w1, "relay before confirm");
        host.frame(32'hF800030A, w2, r);
        chk(r, seal({5'h08, 6'h0E, 8'h15, 3'h1}), "own ack first");
        host.frame(wrAll(REG_CTRL_HIGH, 8'h30), w1, r);
        chk(r, w2, "next device ack");
        host.frame(32'hF800030A, w2, r);
        chk(r, w1, "no-read relays above");
        chk({wReg, wData}, {6'h0D, 8'h30}, "high byte write");
        chk(strobes, 4, "broadcast writes executed");
    endtask : chain_checks

    // Register readback then relayed words, good and corrupted
    task automatic readback_checks();
        w1 = seal(22'h21F0C3);
        host.frame(32'hF800030A, w1, r);
        chk(r, seal({5'h08, 6'h0E, 8'h15, 3'h1}), "register reply");
        host.frame(32'hF800030A, w1 ^ 32'h4, r);
        chk(r, w1, "relayed good word");
        host.frame(32'hF800030A, w1, r);
        chk(r, {w1[31:10], ~crc8(w1[31:10]), 2'b00}, "relayed bad word");
        chk(strobes, 2, "readback writes ignored");
    endtask : readback_checks

    // Pin relays, alert path, slave release and power-down
    task automatic pin_checks();
        cnvN = 1'b0;
        lAlert = 1'b1;
        repeat (10) @(negedge clk);
        chk({cnvR, aOut, aDown}, 3'b011, "convert and alert");
        lAlert = 1'b0;
        aAbove = 1'b1;
        isMaster = 1'b0;
        repeat (10) @(negedge clk);
        chk({aDown, sdoOe, aOe}, 3'b100, "slave release");
        pdN = 1'b0;
        repeat (10) @(negedge clk);
        chk({pdR, devAddr}, 6'h00, "power-down address");
    endtask : pin_checks

    initial begin
        {clk, isMaster, cnvN, pdN, aAbove, lAlert} = 6'h1C;
        rst = 1'b1;
        err_count = 0;
        check_count = 0;
        strobes = 0;
        advances = 0;
        repeat (8) @(negedge clk);
        chk({csR, ckR, sdiR, cnvR, pdR, wAck, devAddr}, 11'h7C0, "reset values");
        rst = 1'b0;
        repeat (6) @(negedge clk);
        write_checks();
        readback_checks();
        chain_checks();
        pin_checks();
        give_verdict();
    end

    // Hang guard
    initial begin
        #2000000;
        err_count++;
        give_verdict();
    end
endmodule : stacked_monitor_chain_link_test
